// >>> hdl/drive_diag_map.svh
/*
  Register offsets, field positions, commands and timing constants of the
  drive diagnostic block. Assumes a 32-bit APB with byte addresses.
*/
`ifndef DRIVE_DIAG_MAP_SVH
`define DRIVE_DIAG_MAP_SVH
// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_TRIP_ACTION 12'h004
`define OFS_USER_TRIP 12'h008
`define OFS_DATE 12'h00c
`define OFS_TIME 12'h010
`define OFS_STATUS 12'h014
`define OFS_IRQ_STAT 12'h018
`define OFS_IRQ_MASK 12'h01c
`define OFS_ACTIVE_TRIP 12'h020
`define OFS_LOG_CODE 12'h040
`define OFS_LOG_SUB 12'h080
`define OFS_LOG_DATE 12'h0c0
`define OFS_LOG_TIME 12'h100
`define OFS_MON 12'h140
// Field positions
`define CTRL_ENABLE_BIT 0
`define CTRL_RUN_BIT 1
`define FREEZE_OFF_BIT 4
`define IRQ_TRIP_BIT 0
`define IRQ_CLEAR_BIT 1
`define IRQ_BOOT_BIT 2
// Sizes, commands, reset values
`define LOG_DEPTH 10
`define MON_COUNT 18
`define LOG_CLEAR_CMD 8'hff
`define CTRL_RESET 32'h0000_0000
// Timing
`define CLK_PERIOD_NS 20
`define ALT_PERIOD_MS 500
`endif

// >>> hdl/drive_diag_pkg.sv
/*
  Types shared by the drive diagnostic block.
  Assumes the map header supplies all numeric constants.
*/
package drive_diag_pkg;
  // Drive status shown on the upper display row
  typedef enum logic [3:0] {
    st_wait_power, st_wait_option, st_uploading, st_inhibit, st_ready,
    st_stop, st_run, st_supply_loss, st_decel, st_dc_inject, st_trip,
    st_undervolt
  } drive_state_t;
  // One monitored value
  typedef logic [15:0] mon_word_t;
endpackage

// >>> hdl/trip_log_if.sv
/*
  Interface between the diagnostic core and the trip history store.
  Assumes both ends run on pclk.
*/
`timescale 1ns/1ns
interface trip_log_if;
  logic push; // New trip enters slot 0
  logic clear; // Empty the whole log
  logic [7:0] code_in; // Trip number
  logic [7:0] sub_in; // Sub-trip, zero if none
  logic [31:0] date_in; // Date stamp
  logic [31:0] time_in; // Time stamp
  logic [3:0] rd_idx; // Slot selected for reading
  logic [7:0] rd_code;
  logic [7:0] rd_sub;
  logic [31:0] rd_date;
  logic [31:0] rd_time;
  modport store (input push, clear, code_in, sub_in, date_in, time_in, rd_idx,
    output rd_code, rd_sub, rd_date, rd_time);
  modport ctrl (output push, clear, code_in, sub_in, date_in, time_in, rd_idx,
    input rd_code, rd_sub, rd_date, rd_time);
endinterface

// >>> hdl/trip_history.sv
/*
  Ten-slot trip history with sub-trip and date/time stamps.
  Assumes push and clear are single-cycle pulses on pclk.
*/
`timescale 1ns/1ns
`include "drive_diag_map.svh"
module trip_history (
  input wire logic pclk,
  input wire logic presetn,
  trip_log_if.store lg
);
  logic [7:0] code [`LOG_DEPTH]; // Slot 0 newest
  logic [7:0] sub [`LOG_DEPTH];
  logic [31:0] date [`LOG_DEPTH];
  logic [31:0] tstamp [`LOG_DEPTH];
  logic hit; // Read index inside the log
  assign hit = lg.rd_idx < 4'(`LOG_DEPTH);

  // Whole log moves in one edge so no read sees half a shift
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `LOG_DEPTH; i++) begin
        code[i] <= '0;
        sub[i] <= '0;
        date[i] <= '0;
        tstamp[i] <= '0;
      end
    end else if (lg.push || lg.clear) begin
      for (int i = `LOG_DEPTH - 1; i > 0; i--) begin
        code[i] <= lg.clear ? '0 : code[i-1];
        sub[i] <= lg.clear ? '0 : sub[i-1];
        date[i] <= lg.clear ? '0 : date[i-1];
        tstamp[i] <= lg.clear ? '0 : tstamp[i-1];
      end
      code[0] <= lg.push ? lg.code_in : '0;
      sub[0] <= lg.push ? lg.sub_in : '0;
      date[0] <= lg.push ? lg.date_in : '0;
      tstamp[0] <= lg.push ? lg.time_in : '0;
    end
  end

  // Numeric trip number goes out, never text
  assign lg.rd_code = hit ? code[lg.rd_idx] : '0;
  assign lg.rd_sub = hit ? sub[lg.rd_idx] : '0;
  assign lg.rd_date = hit ? date[lg.rd_idx] : '0;
  assign lg.rd_time = hit ? tstamp[lg.rd_idx] : '0;

  property p_log_shift;
    @(posedge pclk) disable iff (!presetn)
    lg.push && !lg.clear |=> code[9] == $past(code[8]) && code[0] == $past(lg.code_in);
  endproperty
  a_log_shift: assert property (p_log_shift) else $error("log did not shift");
  property p_log_stamp;
    @(posedge pclk) disable iff (!presetn)
    lg.push |=> date[0] == $past(lg.date_in) && tstamp[0] == $past(lg.time_in);
  endproperty
  a_log_stamp: assert property (p_log_stamp) else $error("stamp not stored");
  property p_log_sub;
    @(posedge pclk) disable iff (!presetn)
    lg.push |=> sub[0] == $past(lg.sub_in);
  endproperty
  a_log_sub: assert property (p_log_sub) else $error("sub-trip not kept");
  property p_log_clear;
    @(posedge pclk) disable iff (!presetn)
    lg.clear && !lg.push |=> code[0] == 8'h00 && code[9] == 8'h00 && date[5] == 32'h0;
  endproperty
  a_log_clear: assert property (p_log_clear) else $error("log not cleared");
endmodule

// >>> hdl/drive_diag.sv
/*
  Drive diagnostic and status core: APB registers, trip history control,
  freeze of monitored values, drive status machine, alarm alternation and
  interrupt. Assumes trip, monitor and motion inputs come from logic on
  pclk; torque-removal and processor answer pins are asynchronous.
*/
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "drive_diag_map.svh"

module drive_diag #(
  parameter int ALT_CYCLES = `ALT_PERIOD_MS * 1000000 / `CLK_PERIOD_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trip source, same clock
  input wire logic trip_event,
  input wire logic [7:0] trip_code,
  input wire logic [7:0] trip_sub,
  input wire logic trip_reset,
  // Drive conditions, same clock
  input wire logic motor_turning,
  input wire logic zero_reference,
  input wire logic supply_loss,
  input wire logic dc_injection,
  input wire logic undervoltage,
  input wire logic option_fitted,
  input wire logic option_changed,
  input wire logic upload_done,
  input wire logic alarm_active,
  input wire logic param_editing,
  input wire logic [`MON_COUNT-1:0][15:0] mon_in,
  // Asynchronous pins
  input wire logic torque_removal_inputs,
  input wire logic power_stage_ack,
  input wire logic option_ack,
  // Outputs
  output logic inverter_enable,
  output logic [3:0] status_code,
  output logic [7:0] display_row2,
  output logic display_alarm,
  output logic irq
);

  // Stage enable of the inverter for a given status
  function automatic logic en_of(drive_diag_pkg::drive_state_t s);
    case (s)
      drive_diag_pkg::st_stop, drive_diag_pkg::st_run,
      drive_diag_pkg::st_supply_loss, drive_diag_pkg::st_decel,
      drive_diag_pkg::st_dc_inject: en_of = 1'b1;
      default: en_of = 1'b0;
    endcase
  endfunction

  // True when addr falls in a window of n words from base
  function automatic logic in_win(logic [11:0] addr, logic [11:0] base, int n);
    in_win = addr >= base && addr < base + 12'(n * 4);
  endfunction

  // Word index of addr inside a window
  function automatic logic [4:0] word_of(logic [11:0] addr, logic [11:0] base);
    logic [11:0] d;
    d = addr - base;
    word_of = d[6:2];
  endfunction

  trip_log_if lg ();

  // Software registers
  logic [31:0] ctrl; // Enable setting and run command
  logic [31:0] trip_action; // Trip action configuration
  logic [31:0] date_now; // Current date value
  logic [31:0] time_now; // Current time value
  logic [2:0] irq_stat; // Sticky events
  logic [2:0] irq_mask; // Enables onto irq
  // Block state
  logic trip_active; // Trip held until reset
  logic [7:0] active_code; // Code of the active trip
  logic [`MON_COUNT-1:0][15:0] mon_frozen; // Values as software sees them
  drive_diag_pkg::drive_state_t state;
  drive_diag_pkg::drive_state_t next_state;
  drive_diag_pkg::drive_state_t run_state; // Status once booted
  logic [31:0] alt_cnt; // Alarm alternation timer
  logic alt_phase; // High while the alarm string shows
  // Synchronisers, first stage read only by the second
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;

  // Two flip-flops on every asynchronous pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {option_ack, power_stage_ack, torque_removal_inputs};
      pin_sync <= pin_meta;
    end
  end

  wire torque_ok = pin_sync[0];
  wire power_ok = pin_sync[1];
  wire option_ok = pin_sync[2];
  wire drive_enable = ctrl[`CTRL_ENABLE_BIT];
  wire run_cmd = ctrl[`CTRL_RUN_BIT];
  wire freeze_off = trip_action[`FREEZE_OFF_BIT];

  // APB decode; writes land on the completing edge only
  wire acc = psel && penable && !pready;
  wire done = psel && penable && pready;
  wire wr = done && pwrite;
  wire in_log = in_win(paddr, `OFS_LOG_CODE, 4 * 16);
  wire in_mon = in_win(paddr, `OFS_MON, `MON_COUNT);
  wire fixed_hit = paddr <= `OFS_ACTIVE_TRIP && paddr[1:0] == 2'b00;
  wire mapped = fixed_hit || in_log || in_mon;
  wire wr_ctrl = wr && paddr == `OFS_CTRL;
  wire wr_action = wr && paddr == `OFS_TRIP_ACTION;
  wire wr_date = wr && paddr == `OFS_DATE;
  wire wr_time = wr && paddr == `OFS_TIME;
  wire wr_istat = wr && paddr == `OFS_IRQ_STAT;
  wire wr_imask = wr && paddr == `OFS_IRQ_MASK;
  // Only the 255 value empties the log; other values are ignored
  wire log_clear = wr && paddr == `OFS_USER_TRIP &&
    pwdata[7:0] == `LOG_CLEAR_CMD;

  // History store connections
  assign lg.push = trip_event;
  assign lg.clear = log_clear;
  assign lg.code_in = trip_code;
  assign lg.sub_in = trip_sub;
  assign lg.date_in = date_now;
  assign lg.time_in = time_now;
  assign lg.rd_idx = paddr[5:2]; // Log windows are 64-byte aligned

  trip_history u_hist (
    .pclk(pclk),
    .presetn(presetn),
    .lg(lg)
  );

  // Read selection
  logic [31:0] rd_word;
  logic [4:0] mon_idx;
  assign mon_idx = word_of(paddr, `OFS_MON);
  always_comb begin
    rd_word = 32'h0;
    if (in_mon) begin
      rd_word = {16'h0, mon_frozen[mon_idx]};
    end else if (in_log) begin
      case (paddr[7:6])
        2'b01: rd_word = {24'h0, lg.rd_code};
        2'b10: rd_word = {24'h0, lg.rd_sub};
        2'b11: rd_word = lg.rd_date;
        default: rd_word = lg.rd_time; // 0x100 window
      endcase
    end else begin
      case (paddr)
        `OFS_CTRL: rd_word = ctrl;
        `OFS_TRIP_ACTION: rd_word = trip_action;
        `OFS_DATE: rd_word = date_now;
        `OFS_TIME: rd_word = time_now;
        `OFS_STATUS: rd_word = {20'h0, ~trip_active, ~undervoltage, drive_enable,
          torque_ok, 1'b0, trip_active, state != drive_diag_pkg::st_wait_power,
          inverter_enable, status_code};
        `OFS_IRQ_STAT: rd_word = {29'h0, irq_stat};
        `OFS_IRQ_MASK: rd_word = {29'h0, irq_mask};
        `OFS_ACTIVE_TRIP: rd_word = {24'h0, active_code};
        default: rd_word = 32'h0;
      endcase
    end
  end

  // Answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc;
      pslverr <= acc && !mapped;
      if (acc) begin
        prdata <= pwrite ? 32'h0 : rd_word;
      end
    end
  end

  // Control registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
      trip_action <= 32'h0;
      date_now <= 32'h0;
      time_now <= 32'h0;
      irq_mask <= 3'h0;
    end else begin
      if (wr_ctrl) ctrl <= pwdata;
      if (wr_action) trip_action <= pwdata;
      if (wr_date) date_now <= pwdata;
      if (wr_time) time_now <= pwdata;
      if (wr_imask) irq_mask <= pwdata[2:0];
    end
  end

  // Trip latch; a new trip in the reset cycle still wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_active <= 1'b0;
      active_code <= 8'h0;
    end else if (trip_event) begin
      trip_active <= 1'b1;
      active_code <= trip_code;
    end else if (trip_reset) begin
      trip_active <= 1'b0;
    end
  end

  // Monitored values track until a trip, then hold for diagnosis
  wire freeze = trip_active && !freeze_off;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_frozen <= '0;
    end else if (!freeze) begin
      mon_frozen <= mon_in;
    end
  end

  // Status once the power-up stages are over, highest priority first
  assign run_state =
    (trip_active || trip_event) ? drive_diag_pkg::st_trip :
    undervoltage ? drive_diag_pkg::st_undervolt :
    (!torque_ok || !drive_enable) ? drive_diag_pkg::st_inhibit :
    !run_cmd ? (motor_turning ? drive_diag_pkg::st_decel :
                drive_diag_pkg::st_ready) :
    supply_loss ? drive_diag_pkg::st_supply_loss :
    dc_injection ? drive_diag_pkg::st_dc_inject :
    zero_reference ? drive_diag_pkg::st_stop :
    drive_diag_pkg::st_run;

  // Power-up waits, then the run-time status
  always_comb begin
    next_state = state;
    case (state)
      drive_diag_pkg::st_wait_power: begin
        if (power_ok) begin
          next_state = option_fitted ? drive_diag_pkg::st_wait_option :
            drive_diag_pkg::st_inhibit;
        end
      end
      drive_diag_pkg::st_wait_option: begin
        if (option_ok) begin
          next_state = option_changed ? drive_diag_pkg::st_uploading :
            drive_diag_pkg::st_inhibit;
        end
      end
      drive_diag_pkg::st_uploading: begin
        if (upload_done) next_state = drive_diag_pkg::st_inhibit;
      end
      default: next_state = run_state;
    endcase
  end

  wire booting = state == drive_diag_pkg::st_wait_power ||
    state == drive_diag_pkg::st_wait_option || state == drive_diag_pkg::st_uploading;
  wire boot_end = booting && next_state == drive_diag_pkg::st_inhibit;

  // Status outputs move with the state on the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= drive_diag_pkg::st_wait_power;
      status_code <= 4'h0;
      inverter_enable <= 1'b0;
      display_row2 <= 8'h0;
    end else begin
      state <= next_state;
      status_code <= 4'(next_state);
      inverter_enable <= en_of(next_state);
      display_row2 <= next_state == drive_diag_pkg::st_trip ?
        (trip_event ? trip_code : active_code) : 8'h0;
    end
  end

  // Alarm alternation timer; it free-runs so the phase is uneven at start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_cnt <= 32'h0;
      alt_phase <= 1'b0;
      display_alarm <= 1'b0;
    end else begin
      if (alt_cnt == 32'(ALT_CYCLES - 1)) begin
        alt_cnt <= 32'h0;
        alt_phase <= !alt_phase;
      end else begin
        alt_cnt <= alt_cnt + 32'h1;
      end
      display_alarm <= alarm_active && !param_editing && alt_phase;
    end
  end

  // Sticky events; a set in the clearing cycle survives
  wire [2:0] ev = {boot_end, log_clear, trip_event};
  wire [2:0] next_irq_stat = (irq_stat & ~(wr_istat ? pwdata[2:0] : 3'h0)) | ev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & irq_mask);
    end
  end

  property p_trip_off;
    @(posedge pclk) disable iff (!presetn)
    trip_event && !booting |=> !inverter_enable && status_code == 4'(drive_diag_pkg::st_trip);
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("trip left output on");
  property p_freeze;
    @(posedge pclk) disable iff (!presetn)
    freeze ##1 freeze |-> $stable(mon_frozen);
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen value moved");
  property p_no_freeze;
    @(posedge pclk) disable iff (!presetn)
    trip_active && freeze_off |=> mon_frozen == $past(mon_in);
  endproperty
  a_no_freeze: assert property (p_no_freeze) else $error("freeze not disabled");
  property p_row2;
    @(posedge pclk) disable iff (!presetn)
    state == drive_diag_pkg::st_trip |-> display_row2 == active_code && !inverter_enable;
  endproperty
  a_row2: assert property (p_row2) else $error("trip code not shown");
endmodule

// >>> verification/apb_host.sv
/*
  Host model: a serial master that reads and writes the drive registers
  over APB. Assumes a slave that raises pready for one cycle per transfer.
*/
`timescale 1ns/1ns
module apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int n_late = 0; // Transfers that never saw pready
  // Idle bus from time zero
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // One transfer; the request stands until pready is seen at a rising edge or 64 edges pass
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Sample pready at rising edges only; no cycle count assumed
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) begin
      n_late++; // Slave never answered
    end
    // Answer taken at the very edge that saw pready, then released
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// >>> verification/tb_drive_diag_and_status.sv
/*
  Self-checking bench: boot states, drive status, trip log, freeze,
  log clear, interrupt, unmapped access and alarm display.
  Assumes apb_host as the serial master and a 50 MHz pclk.
*/
`timescale 1ns/1ns
`include "drive_diag_map.svh"
module tb_drive_trip_log_and_status;
  logic pclk = 1'b0; // 50 MHz
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, err, seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic trip_event = 1'b0;
  logic trip_reset = 1'b0;
  logic [7:0] trip_code = 8'h00;
  logic [7:0] trip_sub = 8'h00;
  logic [7:0] display_row2;
  logic [4:0] cond = 5'h00; // Turning, zero ref, supply loss, dc inj, undervolt
  logic option_fitted = 1'b1;
  logic option_changed = 1'b1;
  logic upload_done = 1'b0;
  logic alarm_active = 1'b0;
  logic param_editing = 1'b0;
  logic [17:0][15:0] mon_in = '0;
  logic torque = 1'b0;
  logic power_ack = 1'b0;
  logic option_ack = 1'b0;
  logic inverter_enable, display_alarm, irq;
  logic [3:0] status_code;
  int n_errors = 0;
  int n_tests = 0;
  // Clock
  always #10 pclk = ~pclk;
  // Short alternation period keeps the alarm test brief
  drive_diag #(.ALT_CYCLES(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trip_event(trip_event),
    .trip_code(trip_code), .trip_sub(trip_sub), .trip_reset(trip_reset),
    .motor_turning(cond[4]), .zero_reference(cond[3]), .supply_loss(cond[2]),
    .dc_injection(cond[1]), .undervoltage(cond[0]), .option_fitted(option_fitted),
    .option_changed(option_changed), .upload_done(upload_done),
    .alarm_active(alarm_active), .param_editing(param_editing), .mon_in(mon_in),
    .torque_removal_inputs(torque), .power_stage_ack(power_ack),
    .option_ack(option_ack), .inverter_enable(inverter_enable),
    .status_code(status_code), .display_row2(display_row2),
    .display_alarm(display_alarm), .irq(irq));
  apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // Verdict and end of run
  task automatic complete_run;
    n_errors += host.n_late;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rv, err);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, rv, err);
    chk(rv, exp);
  endtask
  // Apply drive conditions; sync lag of the torque pin is covered
  task automatic sc(input logic t, input logic [1:0] c, input logic [4:0] k,
      input logic [3:0] s, input logic v);
    @(posedge pclk);
    torque <= t;
    cond <= k;
    wr(`OFS_CTRL, {30'h0, c});
    cyc(4);
    chk({28'h0, status_code}, {28'h0, s});
    chk({31'h0, inverter_enable}, {31'h0, v});
  endtask
  // One-cycle trip pulse, outputs due one edge later
  task automatic trip(input logic [7:0] c, input logic [7:0] s);
    @(posedge pclk);
    trip_event <= 1'b1;
    trip_code <= c;
    trip_sub <= s;
    @(posedge pclk);
    trip_event <= 1'b0;
    @(negedge pclk);
    chk({28'h0, status_code}, 32'ha);
    chk({31'h0, inverter_enable}, 32'h0);
    chk({24'h0, display_row2}, {24'h0, c});
  endtask
  task automatic untrip;
    @(posedge pclk);
    trip_reset <= 1'b1;
    @(posedge pclk);
    trip_reset <= 1'b0;
    cyc(2);
  endtask
  // Was the alarm string ever shown in 24 cycles
  task automatic watch;
    seen = 1'b0;
    repeat (24) begin
      @(negedge pclk);
      seen = seen | display_alarm;
    end
  endtask
  // Watchdog, far beyond the expected run
  initial begin
    #400000;
    n_errors++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    chk({28'h0, status_code}, 32'h0);
    rdc(`OFS_CTRL, `CTRL_RESET);
    @(posedge pclk);
    power_ack <= 1'b1;
    cyc(4);
    chk({28'h0, status_code}, 32'h1);
    @(posedge pclk);
    option_ack <= 1'b1;
    cyc(4);
    chk({28'h0, status_code}, 32'h2);
    @(posedge pclk);
    upload_done <= 1'b1;
    cyc(4);
    chk({28'h0, status_code}, 32'h3);
    $display("boot test done");
    sc(1'b0, 2'h3, 5'h00, 4'h3, 1'b0);
    sc(1'b1, 2'h2, 5'h00, 4'h3, 1'b0);
    sc(1'b1, 2'h1, 5'h00, 4'h4, 1'b0);
    sc(1'b1, 2'h1, 5'h10, 4'h8, 1'b1);
    sc(1'b1, 2'h3, 5'h08, 4'h5, 1'b1);
    sc(1'b1, 2'h3, 5'h04, 4'h7, 1'b1);
    sc(1'b1, 2'h3, 5'h02, 4'h9, 1'b1);
    sc(1'b1, 2'h3, 5'h01, 4'hb, 1'b0);
    sc(1'b1, 2'h3, 5'h00, 4'h6, 1'b1);
    rdc(`OFS_STATUS, 32'h0000_0f36);
    $display("status test done");
    // Eleven trips, so the first falls off the end; odd codes carry a sub-trip
    for (int i = 1; i <= 11; i++) begin
      wr(`OFS_DATE, 32'hd000_0000 + i);
      wr(`OFS_TIME, 32'h7000_0000 + i);
      trip(i[7:0], i[0] ? i[7:0] : 8'h00);
    end
    for (int n = 0; n < 10; n++) begin
      rdc(`OFS_LOG_CODE + 12'(4 * n), 32'(11 - n));
      rdc(`OFS_LOG_SUB + 12'(4 * n), (n % 2) ? 32'h0 : 32'(11 - n));
      rdc(`OFS_LOG_DATE + 12'(4 * n), 32'hd000_0000 + 32'(11 - n));
      rdc(`OFS_LOG_TIME + 12'(4 * n), 32'h7000_0000 + 32'(11 - n));
    end
    $display("log test done");
    host.xfer(1'b0, `OFS_IRQ_STAT, 32'h0, rv, err);
    chk({31'h0, rv[0]}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(`OFS_IRQ_MASK, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    wr(`OFS_IRQ_STAT, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    untrip();
    chk({28'h0, status_code}, 32'h6);
    $display("interrupt test done");
    // Near miss first: only 255 empties the log
    wr(`OFS_USER_TRIP, 32'hfe);
    rdc(`OFS_LOG_CODE, 32'hb);
    wr(`OFS_USER_TRIP, 32'hff);
    rdc(`OFS_LOG_CODE, 32'h0);
    rdc(`OFS_LOG_CODE + 12'h024, 32'h0);
    host.xfer(1'b0, `OFS_IRQ_STAT, 32'h0, rv, err);
    chk({31'h0, rv[1]}, 32'h1);
    $display("clear test done");
    @(posedge pclk);
    mon_in <= {18{16'h1111}};
    cyc(2);
    trip(8'h21, 8'h00);
    @(posedge pclk);
    mon_in <= {18{16'h2222}};
    cyc(2);
    rdc(`OFS_MON, 32'h1111);
    rdc(`OFS_MON + 12'h044, 32'h1111);
    untrip();
    rdc(`OFS_MON, 32'h2222);
    wr(`OFS_TRIP_ACTION, 32'h10);
    trip(8'h22, 8'h00);
    @(posedge pclk);
    mon_in <= {18{16'h3333}};
    cyc(2);
    rdc(`OFS_MON, 32'h3333);
    untrip();
    $display("freeze test done");
    host.xfer(1'b0, 12'h3fc, 32'h0, rv, err);
    chk({31'h0, err}, 32'h1);
    $display("unmapped test done");
    @(posedge pclk);
    alarm_active <= 1'b1;
    param_editing <= 1'b1;
    watch();
    chk({31'h0, seen}, 32'h0);
    @(posedge pclk);
    param_editing <= 1'b0;
    watch();
    chk({31'h0, seen}, 32'h1);
    $display("alarm test done");
    complete_run();
  end
endmodule
